// [ebsf_mem_model.sv]
`timescale 1ns/1ps
module ebsf_mem_model (
  // clock
  input  wire logic                        i_clk,
  // device pads as seen on the wires
  input  wire logic [ebsf_pkg::CTL_W-1:0]  i_ctl,
  input  wire logic [ebsf_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [ebsf_pkg::DATA_W-1:0] i_data,
  input  wire logic [3:0]                  i_waits,
  // answer to the device
  output logic                             o_ready,
  output logic      [ebsf_pkg::DATA_W-1:0] o_data,
  output logic      [ebsf_pkg::DATA_W-1:0] o_last_wr
);
  import ebsf_pkg::*;
  logic [3:0]        cnt = 4'h0;
  logic [1:0]        hold = 2'h0;
  logic              we_q = 1'b1;
  logic [DATA_W-1:0] word = 16'h0;

  // --------------------------------------------------------------
  // wait states
  // --------------------------------------------------------------
  // ready drops between cycles so a stale high never ends the next one early
  always_ff @(posedge i_clk) begin
    cnt <= i_ctl[CTL_STB] ? 4'h0 : cnt + ((cnt != 4'hf) ? 4'h1 : 4'h0);
  end
  assign o_ready = !i_ctl[CTL_STB] && (cnt >= i_waits);

  // --------------------------------------------------------------
  // read data and write capture
  // --------------------------------------------------------------
  // once released the bus keeps the last word while hold counts down from 3, then shows a changing pattern
  always_ff @(posedge i_clk) begin
    hold <= !i_ctl[CTL_RD] ? 2'h3 : hold - ((hold != 2'h0) ? 2'h1 : 2'h0);
    we_q <= i_ctl[CTL_WE];
    if (!i_ctl[CTL_RD]) begin
      word <= i_addr ^ 16'h5a3c;
    end else if (hold == 2'h0) begin
      word <= ~word;
    end
    if (i_ctl[CTL_WE] && !we_q) begin
      o_last_wr <= i_data;
    end
  end
  assign o_data = !i_ctl[CTL_RD] ? (i_addr ^ 16'h5a3c) : word;
endmodule

// [ebsf_pad.sv]
`timescale 1ns/1ps
module ebsf_pad #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0,
  parameter logic         RST_OEN = 1'b0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  // drive request
  input  wire logic [W-1:0] i_val,
  input  wire logic         i_float,
  // pad side
  output logic      [W-1:0] o_out,
  output logic      [W-1:0] o_oe_n
);
  import ebsf_pkg::*;

  // registering value and enable together keeps them glitch free and aligned
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_out  <= RST_VAL;
      o_oe_n <= {W{RST_OEN}};
    end else begin
      o_out  <= i_val;
      o_oe_n <= {W{i_float}};
    end
  end

endmodule

// [ebsf_pkg.sv]
package ebsf_pkg;

  // ----------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 16;
  localparam int GADDR_W = 15;

  // ----------------------------------------------------------------
  // control pad bit positions (all active low)
  // ----------------------------------------------------------------
  localparam int CTL_W   = 7;
  localparam int CTL_PS  = 0;
  localparam int CTL_DS  = 1;
  localparam int CTL_IS  = 2;
  localparam int CTL_RD  = 3;
  localparam int CTL_WE  = 4;
  localparam int CTL_RW  = 5;
  localparam int CTL_STB = 6;

  // ----------------------------------------------------------------
  // status pad bit positions (all active low except the flag)
  // ----------------------------------------------------------------
  localparam int STS_W    = 4;
  localparam int STS_ACK  = 0;
  localparam int STS_INS  = 1;
  localparam int STS_FLAG = 2;
  localparam int STS_IRQ  = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CTL_W-1:0]  CTL_IDLE    = 7'h7f;
  localparam logic [STS_W-1:0]  STS_RST     = 4'hf;
  localparam logic              FLAG_RST    = 1'b1;
  localparam logic [6:0]        PIN_SYNC_RST = 7'h6f;
  localparam int                SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SP_PROG   = 2'h0,
    SP_DATA   = 2'h1,
    SP_IO     = 2'h2,
    SP_GLOBAL = 2'h3
  } ebsf_space_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACT  = 2'b01,
    ST_DONE = 2'b11,
    ST_HOLD = 2'b10
  } ebsf_state_t;

endpackage

// [ebsf_sync.sv]
`timescale 1ns/1ps
module ebsf_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  import ebsf_pkg::*;

  // first stage is read only by the second stage
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta <= RST;
      o_q  <= RST;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule

// [ebsf_top.sv]
// Summary of operation
// - write strobe falls as data drive begins
// - data held through write strobe rising edge
// - write strobe used for all spaces
// - write strobe floats in hold or off
// - hold floats address and controls, and data except while ram read data is driven
// - cede ack low while in hold
// - cede ack floats when off
// - global request low on global accesses
// - global region limited to 32K words
// - fetch indicator low on instruction fetches
// - fetch indicator grants ram access in hold
// - fetch indicator floats when off
// - branch condition true when sampled low
// - flag latch set by instruction or status load
// - flag high at reset, floats when off
// - irq ack low during vector fetch
// - irq ack floats when off
// - direction pin gives ram read or write
// - address pins are inputs during ram access
`timescale 1ns/1ps
module ebsf_top (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  // core cycle request
  input  wire logic                          i_cyc_req,
  input  wire ebsf_pkg::ebsf_space_t         i_cyc_space,
  input  wire logic                          i_cyc_write,
  input  wire logic                          i_cyc_fetch,
  input  wire logic                          i_cyc_vector,
  input  wire logic [ebsf_pkg::ADDR_W-1:0]   i_cyc_addr,
  input  wire logic [ebsf_pkg::DATA_W-1:0]   i_cyc_wdata,
  output logic                               o_cyc_done,
  output logic      [ebsf_pkg::DATA_W-1:0]   o_cyc_rdata,
  output logic                               o_hold_active,
  // core flag and branch control
  input  wire logic                          i_flag_set,
  input  wire logic                          i_flag_clr,
  input  wire logic                          i_stw_load,
  input  wire logic                          i_stw_flag,
  input  wire logic                          i_brt_sample,
  output logic                               o_brt_take,
  // on-chip ram access port
  output logic                               o_dma_req,
  output logic                               o_dma_write,
  output logic      [ebsf_pkg::ADDR_W-1:0]   o_dma_addr,
  output logic      [ebsf_pkg::DATA_W-1:0]   o_dma_wdata,
  input  wire logic [ebsf_pkg::DATA_W-1:0]   i_dma_rdata,
  // plain input pins
  input  wire logic                          i_hold_req_n,
  input  wire logic                          i_ready,
  input  wire logic                          i_branch_test_n,
  input  wire logic                          i_off_n,
  // address pins
  input  wire logic [ebsf_pkg::ADDR_W-1:0]   i_addr,
  output logic      [ebsf_pkg::ADDR_W-1:0]   o_addr,
  output logic      [ebsf_pkg::ADDR_W-1:0]   o_addr_oe_n,
  // data pins
  input  wire logic [ebsf_pkg::DATA_W-1:0]   i_data,
  output logic      [ebsf_pkg::DATA_W-1:0]   o_data,
  output logic      [ebsf_pkg::DATA_W-1:0]   o_data_oe_n,
  // memory control pins: ps, ds, is, rd, we, rw, strobe
  input  wire logic                          i_rw,
  input  wire logic                          i_strobe_n,
  output logic      [ebsf_pkg::CTL_W-1:0]    o_ctl,
  output logic      [ebsf_pkg::CTL_W-1:0]    o_ctl_oe_n,
  // global request pin
  input  wire logic                          i_global_req_n,
  output logic                               o_global_req_n,
  output logic                               o_global_req_oe_n,
  // status pins: cede ack, fetch ind, flag, irq ack
  output logic      [ebsf_pkg::STS_W-1:0]    o_sts,
  output logic      [ebsf_pkg::STS_W-1:0]    o_sts_oe_n
);
  import ebsf_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0]               pin_s;
  logic [ADDR_W+DATA_W-1:0] bus_s;
  logic                     hold_req;
  logic                     ready_s;
  logic                     brt_s;
  logic                     off_s;
  logic                     greq_s;
  logic                     stb_s;
  logic                     rw_s;
  logic [ADDR_W-1:0]        addr_s;
  logic [DATA_W-1:0]        data_s;

  ebsf_sync #(.W(7), .RST(PIN_SYNC_RST)) u_sync_pin (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_d       ({i_hold_req_n, i_ready, i_branch_test_n, i_off_n,
                 i_global_req_n, i_strobe_n, i_rw}),
    .o_q       (pin_s)
  );

  // bus words are synchronised every cycle and used only at a strobe fall or a completing ready
  ebsf_sync #(.W(ADDR_W+DATA_W), .RST('0)) u_sync_bus (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_d       ({i_addr, i_data}),
    .o_q       (bus_s)
  );

  assign hold_req = ~pin_s[6];
  assign ready_s  = pin_s[5];
  assign brt_s    = pin_s[4];
  assign off_s    = pin_s[3];
  assign greq_s   = pin_s[2];
  assign stb_s    = pin_s[1];
  assign rw_s     = pin_s[0];
  assign addr_s   = bus_s[ADDR_W+DATA_W-1:DATA_W];
  assign data_s   = bus_s[DATA_W-1:0];

  // ----------------------------------------------------------------
  // bus cycle state machine
  // ----------------------------------------------------------------
  ebsf_state_t       state;
  ebsf_state_t       next_state;
  ebsf_space_t       cur_space;
  logic              cur_write;
  logic              cur_fetch;
  logic              cur_vector;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-1:0] cur_wdata;
  logic [1:0]        act_wait;
  logic              ready_ok;

  // ready lags the pads by a strobe plus the synchroniser, so an old high is ignored
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      act_wait <= 2'h0;
    end else if (state != ST_ACT) begin
      act_wait <= 2'h0;
    end else if (!ready_ok) begin
      act_wait <= act_wait + 2'h1;
    end
  end

  assign ready_ok = (act_wait == 2'(SYNC_STAGES + 1));

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (hold_req) begin
          next_state = ST_HOLD;
        end else if (i_cyc_req) begin
          next_state = ST_ACT;
        end
      end
      ST_ACT: begin
        if (ready_ok && ready_s) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      ST_HOLD: begin
        if (!hold_req) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_space  <= SP_PROG;
      cur_write  <= 1'b0;
      cur_fetch  <= 1'b0;
      cur_vector <= 1'b0;
      cur_addr   <= '0;
      cur_wdata  <= '0;
    end else if (state == ST_IDLE && next_state == ST_ACT) begin
      cur_space  <= i_cyc_space;
      cur_write  <= i_cyc_write;
      cur_fetch  <= i_cyc_fetch;
      cur_vector <= i_cyc_vector;
      cur_wdata  <= i_cyc_wdata;
      if (i_cyc_space == SP_GLOBAL) begin
        cur_addr <= {1'b0, i_cyc_addr[GADDR_W-1:0]};
      end else begin
        cur_addr <= i_cyc_addr;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cyc_done  <= 1'b0;
      o_cyc_rdata <= '0;
    end else begin
      o_cyc_done <= (state == ST_ACT) && ready_ok && ready_s;
      if (state == ST_ACT && ready_ok && ready_s && !cur_write) begin
        o_cyc_rdata <= data_s;
      end
    end
  end

  assign o_hold_active = (state == ST_HOLD);

  // ----------------------------------------------------------------
  // external ram access while the bus is ceded
  // ----------------------------------------------------------------
  logic dma_grant;
  logic stb_d;
  logic dma_start;
  logic dma_rd_cap;
  logic dma_rd_drive;
  logic [DATA_W-1:0] dma_rdata;

  // grant follows the master's request, only while in hold
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dma_grant <= 1'b0;
    end else begin
      dma_grant <= (state == ST_HOLD) && hold_req && !greq_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stb_d <= 1'b1;
    end else begin
      stb_d <= stb_s;
    end
  end

  assign dma_start = dma_grant && stb_d && !stb_s;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dma_req   <= 1'b0;
      o_dma_write <= 1'b0;
      o_dma_addr  <= '0;
      o_dma_wdata <= '0;
      dma_rd_cap  <= 1'b0;
    end else begin
      o_dma_req  <= dma_start;
      dma_rd_cap <= o_dma_req && !o_dma_write;
      if (dma_start) begin
        o_dma_write <= !rw_s;
        o_dma_addr  <= addr_s;
        o_dma_wdata <= data_s;
      end
    end
  end

  // read data is returned the cycle after the request and held until the strobe ends
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dma_rdata    <= '0;
      dma_rd_drive <= 1'b0;
    end else begin
      if (dma_rd_cap) begin
        dma_rdata <= i_dma_rdata;
      end
      if (dma_rd_cap) begin
        dma_rd_drive <= 1'b1;
      end else if (stb_s || !dma_grant) begin
        dma_rd_drive <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // flag latch and branch test
  // ----------------------------------------------------------------
  logic flag;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flag <= FLAG_RST;
    end else if (i_stw_load) begin
      flag <= i_stw_flag;
    end else if (i_flag_set) begin
      flag <= 1'b1;
    end else if (i_flag_clr) begin
      flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_brt_take <= 1'b0;
    end else if (i_brt_sample) begin
      o_brt_take <= !brt_s;
    end
  end

  // ----------------------------------------------------------------
  // pad drive
  // ----------------------------------------------------------------
  logic              active;
  logic              in_hold;
  logic              data_drive;
  logic [CTL_W-1:0]  ctl_val;
  logic [STS_W-1:0]  sts_val;
  logic [DATA_W-1:0] data_val;

  assign active     = (state == ST_ACT);
  assign in_hold    = (state == ST_HOLD);
  // write data spans the whole strobe and the cycle after its rise
  assign data_drive = ((active || state == ST_DONE) && cur_write)
                      || (in_hold && dma_rd_drive);
  assign data_val   = in_hold ? dma_rdata : cur_wdata;

  always_comb begin
    ctl_val          = CTL_IDLE;
    ctl_val[CTL_PS]  = !(active && cur_space == SP_PROG);
    ctl_val[CTL_DS]  = !(active && (cur_space == SP_DATA || cur_space == SP_GLOBAL));
    ctl_val[CTL_IS]  = !(active && cur_space == SP_IO);
    ctl_val[CTL_RD]  = !(active && !cur_write);
    ctl_val[CTL_WE]  = !(active && cur_write);
    ctl_val[CTL_RW]  = !(active && cur_write);
    ctl_val[CTL_STB] = !active;
  end

  always_comb begin
    sts_val           = STS_RST;
    sts_val[STS_ACK]  = !in_hold;
    sts_val[STS_INS]  = in_hold ? !dma_grant : !(active && cur_fetch);
    sts_val[STS_FLAG] = flag;
    sts_val[STS_IRQ]  = !(active && cur_vector);
  end

  ebsf_pad #(.W(ADDR_W), .RST_VAL('0), .RST_OEN(1'b0)) u_pad_addr (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_val     (cur_addr),
    .i_float   (!off_s || in_hold),
    .o_out     (o_addr),
    .o_oe_n    (o_addr_oe_n)
  );

  ebsf_pad #(.W(DATA_W), .RST_VAL('0), .RST_OEN(1'b1)) u_pad_data (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_val     (data_val),
    .i_float   (!off_s || !data_drive),
    .o_out     (o_data),
    .o_oe_n    (o_data_oe_n)
  );

  ebsf_pad #(.W(CTL_W), .RST_VAL(CTL_IDLE), .RST_OEN(1'b0)) u_pad_ctl (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_val     (ctl_val),
    .i_float   (!off_s || in_hold),
    .o_out     (o_ctl),
    .o_oe_n    (o_ctl_oe_n)
  );

  ebsf_pad #(.W(1), .RST_VAL(1'b1), .RST_OEN(1'b0)) u_pad_greq (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_val     (!(active && cur_space == SP_GLOBAL)),
    .i_float   (!off_s || in_hold),
    .o_out     (o_global_req_n),
    .o_oe_n    (o_global_req_oe_n)
  );

  ebsf_pad #(.W(STS_W), .RST_VAL(STS_RST), .RST_OEN(1'b0)) u_pad_sts (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_val     (sts_val),
    .i_float   (!off_s),
    .o_out     (o_sts),
    .o_oe_n    (o_sts_oe_n)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  we_data_drive_a: assert property (
    (!o_ctl[CTL_WE] && !o_ctl_oe_n[CTL_WE]) |-> (o_data_oe_n == '0))
    else $error("write strobe low without data drive");

  we_rise_hold_a: assert property (
    ($rose(o_ctl[CTL_WE]) && !o_ctl_oe_n[CTL_WE]) |-> (o_data_oe_n == '0) && $stable(o_data))
    else $error("data not held at write strobe rise");

  we_one_space_a: assert property (
    (!o_ctl[CTL_WE] && !o_ctl_oe_n[CTL_WE]) |-> $onehot(~o_ctl[CTL_IS:CTL_PS]))
    else $error("write strobe without one space select");

  hold_float_a: assert property (
    (state == ST_HOLD) |=> (o_ctl_oe_n == '1) && (o_addr_oe_n == '1))
    else $error("controls driven during hold");

  hold_ack_a: assert property (
    (state == ST_HOLD && off_s) |=> !o_sts[STS_ACK] && !o_sts_oe_n[STS_ACK])
    else $error("cede ack not low in hold");

  off_float_a: assert property (
    !off_s |=> (o_sts_oe_n == '1) && o_global_req_oe_n && (o_ctl_oe_n == '1))
    else $error("pin driven while off");

  global_req_a: assert property (
    (active && cur_space == SP_GLOBAL && off_s) |=> !o_global_req_n && !o_global_req_oe_n)
    else $error("global request missing");

  fetch_ind_a: assert property (
    (active && cur_fetch) |=> !o_sts[STS_INS])
    else $error("fetch indicator not low");

  ram_grant_a: assert property (
    (in_hold && dma_grant) |=> !o_sts[STS_INS])
    else $error("ram grant not shown");

  irq_ack_a: assert property (
    (active && cur_vector) |=> !o_sts[STS_IRQ])
    else $error("irq ack not low on vector fetch");

  flag_set_a: assert property (
    (i_flag_set && !i_stw_load) |=> flag ##1 o_sts[STS_FLAG])
    else $error("flag not set");

  branch_take_a: assert property (
    i_brt_sample |=> (o_brt_take == !$past(brt_s)))
    else $error("branch test sampled wrong");

  ram_addr_a: assert property (
    dma_start |=> o_dma_req && (o_dma_addr == $past(addr_s)) && (o_dma_write == !$past(rw_s)))
    else $error("ram access address wrong");

  finish_cycle_a: assert property (
    (state == ST_ACT) |=> (state == ST_ACT || state == ST_DONE))
    else $error("cycle cut short");

  leave_hold_a: assert property (
    (state == ST_HOLD && !hold_req) |=> (state == ST_IDLE) ##1 !o_hold_active)
    else $error("hold not released");

  write_seen_c: cover property (active && cur_write ##[1:20] o_cyc_done);
  hold_seen_c: cover property (state == ST_IDLE ##1 state == ST_HOLD ##[1:50] state == ST_IDLE);
  dma_write_c: cover property (dma_start && !rw_s);
  global_read_c: cover property (active && cur_space == SP_GLOBAL && !cur_write ##[1:20] o_cyc_done);

endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import ebsf_pkg::*;
  logic              i_clk = 1'b0;
  logic              i_reset_n = 1'b0;
  int                n_fail = 0;
  int                checked = 0;
  logic [31:0]       seed = 32'h82117849;
  logic              i_cyc_req, i_cyc_write, i_cyc_fetch, i_cyc_vector, o_cyc_done;
  ebsf_space_t       i_cyc_space;
  logic [ADDR_W-1:0] i_cyc_addr, i_addr, o_addr, o_addr_oe_n, o_dma_addr, dma_addr;
  logic [DATA_W-1:0] i_cyc_wdata, o_cyc_rdata, i_data, o_data, o_data_oe_n, dma_data;
  logic [DATA_W-1:0] o_dma_wdata, i_dma_rdata, mem_data, last_wr;
  logic              i_flag_set, i_flag_clr, i_stw_load, i_stw_flag, i_brt_sample;
  logic              o_brt_take, o_hold_active, o_dma_req, o_dma_write, i_ready;
  logic              i_hold_req_n, i_branch_test_n, i_off_n, i_rw, i_strobe_n;
  logic              dma_rw, dma_stb_n, dma_breq_n, dma_drv, exp_f;
  logic              i_global_req_n, o_global_req_n, o_global_req_oe_n;
  logic [CTL_W-1:0]  o_ctl, o_ctl_oe_n;
  logic [STS_W-1:0]  o_sts, o_sts_oe_n;
  logic [3:0]        waits;
  logic [31:0]       r;

  always #12.5 i_clk = ~i_clk;

  // --------------------------------------------------------------
  // wires: the device where it drives, else the far side
  // --------------------------------------------------------------
  assign i_addr = (o_addr & ~o_addr_oe_n) | (dma_addr & o_addr_oe_n);
  assign i_data = (o_data & ~o_data_oe_n) | ((dma_drv ? dma_data : mem_data) & o_data_oe_n);
  assign i_rw = o_ctl_oe_n[CTL_RW] ? dma_rw : o_ctl[CTL_RW];
  assign i_strobe_n = o_ctl_oe_n[CTL_STB] ? dma_stb_n : o_ctl[CTL_STB];
  assign i_global_req_n = o_global_req_oe_n ? dma_breq_n : o_global_req_n;
  always_ff @(posedge i_clk) begin
    if (o_dma_req) begin
      i_dma_rdata <= o_dma_addr ^ 16'hc3a5;
    end
  end

  ebsf_mem_model mem (.i_clk, .i_ctl(o_ctl_oe_n[0] ? CTL_IDLE : o_ctl), .i_addr, .i_data,
    .i_waits(waits), .o_ready(i_ready), .o_data(mem_data), .o_last_wr(last_wr));

  ebsf_top dut (.i_clk, .i_reset_n, .i_cyc_req, .i_cyc_space, .i_cyc_write, .i_cyc_fetch,
    .i_cyc_vector, .i_cyc_addr, .i_cyc_wdata, .o_cyc_done, .o_cyc_rdata, .o_hold_active,
    .i_flag_set, .i_flag_clr, .i_stw_load, .i_stw_flag, .i_brt_sample, .o_brt_take,
    .o_dma_req, .o_dma_write, .o_dma_addr, .o_dma_wdata, .i_dma_rdata, .i_hold_req_n,
    .i_ready, .i_branch_test_n, .i_off_n, .i_addr, .o_addr, .o_addr_oe_n, .i_data, .o_data,
    .o_data_oe_n, .i_rw, .i_strobe_n, .o_ctl, .o_ctl_oe_n, .i_global_req_n,
    .o_global_req_n, .o_global_req_oe_n, .o_sts, .o_sts_oe_n);

  // --------------------------------------------------------------
  // bench tasks
  // --------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // inputs change 2 ns after the edge, outputs are read at the same point
  task automatic tick();
    @(posedge i_clk);
    #2;
  endtask

  task automatic wait_sts(input int b, input logic v);
    for (int n = 0; n < 20 && o_sts[b] !== v; n++) tick();
    chk("status pin", o_sts[b], v);
    if (o_sts[b] !== v) print_verdict();
  endtask

  task automatic core(input ebsf_space_t sp, input logic wr, fe, ve, hold_mid);
    logic [CTL_W-1:0] ctl_and;
    logic [STS_W-1:0] sts_and;
    logic             glob_and;
    logic [15:0]      ea, a_seen;
    int               sel;
    r = xs();
    ea = (sp == SP_GLOBAL) ? {1'b0, r[14:0]} : r[15:0];
    sel = (sp == SP_PROG) ? CTL_PS : (sp == SP_IO) ? CTL_IS : CTL_DS;
    {i_cyc_req, i_cyc_space, i_cyc_write, i_cyc_fetch, i_cyc_vector} = {1'b1, sp, wr, fe, ve};
    {i_cyc_wdata, i_cyc_addr} = r;
    {ctl_and, sts_and, glob_and, a_seen} = '1;
    for (int n = 0; n < 60 && o_cyc_done !== 1'b1; n++) begin
      tick();
      ctl_and &= o_ctl;
      sts_and &= o_sts;
      glob_and &= o_global_req_n;
      if (o_ctl[CTL_STB] === 1'b0) a_seen = o_addr;
      if (hold_mid) i_hold_req_n = 1'b0;
    end
    if (o_cyc_done !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    i_cyc_req = 1'b0;
    chk("space select", ctl_and[sel], 1'b0);
    chk("write enable", ctl_and[CTL_WE], !wr);
    chk("read select", ctl_and[CTL_RD], wr);
    chk("global request", glob_and, sp != SP_GLOBAL);
    chk("fetch ind", sts_and[STS_INS], !fe);
    chk("irq ack", sts_and[STS_IRQ], !ve);
    chk("cede ack", sts_and[STS_ACK], 1'b1);
    chk("address", a_seen, ea);
    if (!wr) chk("read data", o_cyc_rdata, ea ^ 16'h5a3c);
    repeat (2) tick();
    if (wr) chk("write data", last_wr, r[31:16]);
  endtask

  task automatic dma(input logic rd);
    r = xs();
    {dma_addr, dma_data, dma_rw, dma_drv} = {r, rd, !rd};
    repeat (3) tick();
    dma_stb_n = 1'b0;
    for (int n = 0; n < 20 && o_dma_req !== 1'b1; n++) tick();
    chk("ram request", o_dma_req, 1'b1);
    if (o_dma_req !== 1'b1) print_verdict();
    chk("ram address", o_dma_addr, dma_addr);
    chk("ram write", o_dma_write, !rd);
    if (!rd) chk("ram data", o_dma_wdata, dma_data);
    repeat (3) tick();
    if (rd) chk("ram read", o_data & ~o_data_oe_n, dma_addr ^ 16'hc3a5);
    {dma_stb_n, dma_drv} = 2'b10;
    repeat (3) tick();
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {i_cyc_req, i_cyc_write, i_cyc_fetch, i_cyc_vector, i_cyc_addr, i_cyc_wdata} = '0;
    {i_flag_set, i_flag_clr, i_stw_load, i_stw_flag, i_brt_sample, dma_drv} = '0;
    {i_hold_req_n, i_off_n, i_branch_test_n, dma_rw, dma_stb_n, dma_breq_n} = '1;
    {i_cyc_space, dma_addr, dma_data, waits, exp_f} = {SP_PROG, 36'h0, 1'b1};
    repeat (20) tick();
    chk("reset pads", {5'h0, o_ctl, o_sts}, {5'h0, CTL_IDLE, STS_RST});
    i_reset_n = 1'b1;
    tick();
    // every space read and written, waits and fetch kinds at random
    for (int i = 0; i < 32; i++) begin
      r = xs();
      waits = r[8:5];
      core(ebsf_space_t'(i % 4), i[2], !i[2] & r[3], !i[2] & !r[3] & r[4], 1'b0);
    end
    // cede request lands in the middle of a slow write
    waits = 4'hc;
    core(SP_DATA, 1'b1, 1'b0, 1'b0, 1'b1);
    wait_sts(STS_ACK, 1'b0);
    chk("addr float", o_addr_oe_n, 16'hffff);
    chk("ctl float", {9'h0, o_ctl_oe_n}, 16'h7f);
    chk("data float", o_data_oe_n, 16'hffff);
    dma_breq_n = 1'b0;
    wait_sts(STS_INS, 1'b0);
    dma(1'b0);
    dma(1'b1);
    dma_breq_n = 1'b1;
    i_hold_req_n = 1'b1;
    wait_sts(STS_ACK, 1'b1);
    repeat (2) tick();
    chk("addr drive", o_addr_oe_n, 16'h0);
    // flag latch and branch test
    for (int i = 0; i < 16; i++) begin
      r = xs();
      {i_flag_set, i_flag_clr, i_stw_load, i_stw_flag} = r[3:0];
      i_branch_test_n = r[4];
      exp_f = r[1] ? r[0] : r[3] ? 1'b1 : r[2] ? 1'b0 : exp_f;
      tick();
      {i_flag_set, i_flag_clr, i_stw_load} = 3'h0;
      tick();
      chk("flag", o_sts[STS_FLAG], exp_f);
      tick();
      i_brt_sample = 1'b1;
      tick();
      i_brt_sample = 1'b0;
      chk("branch take", o_brt_take, !r[4]);
    end
    i_off_n = 1'b0;
    repeat (4) tick();
    chk("status float", {12'h0, o_sts_oe_n}, 16'hf);
    chk("ctl off", {9'h0, o_ctl_oe_n}, 16'h7f);
    {i_off_n, i_flag_clr} = 2'b11;
    tick();
    i_flag_clr = 1'b0;
    i_reset_n = 1'b0;
    tick();
    chk("flag reset", o_sts[STS_FLAG], FLAG_RST);
    print_verdict();
  end
endmodule
